// ---- logic/adcm_top.sv ----
// Digital control and double-data-rate output side of a pipelined 14-bit converter.
// Assumes the analog core hands over one digitised word per sample clock and that the
// strap levels arrive already quantised by comparators into level codes.
// The sample clock is treated as a plain asynchronous pin; its falling edge is found by
// oversampling, so it must run at no more than a quarter of the system clock rate.
// Leaving the on state flushes the pipeline and buffer and starts no new strobe, but a word
// already in its odd half is still sent with its even half and rising strobe.
`timescale 1ns/1ps

module adcm_top #(
	parameter int LATENCY   = 8,
	parameter int EXIT_PD   = adcm_pkg::EXIT_PD_CYC,
	parameter int EXIT_SL   = adcm_pkg::EXIT_SL_CYC
) (
	input  wire logic                          clk_sys,
	input  wire logic                          sys_rst,
	input  wire logic                          sample_clk,
	input  wire logic [1:0]                    power_state_select,
	input  wire logic [1:0]                    clock_format_select,
	input  wire logic [adcm_pkg::SAMPLE_W-1:0] core_word,
	input  wire logic                          core_over,
	output logic      [6:0]                    sample_bits,
	output logic                               output_strobe,
	output logic                               over_range_flag,
	output logic                               data_valid,
	output logic                               settling,
	output logic                               clock_single_ended
);

	// Elaboration checks refuse latency values the shift pipeline cannot serve and exit counts below one.
	if (LATENCY < 2 || LATENCY > 32) begin : g_bad_latency
		$error("LATENCY out of range");
	end
	if (EXIT_PD < 1 || EXIT_SL < 1) begin : g_bad_exit
		$error("Exit counts must be positive");
	end

	// Three-stage synchronisers for pins from outside the clock domain.
	logic [2:0] clk_sync;
	logic [1:0] pwr_s1, pwr_s2, pwr_s3, cf_s1, cf_s2, cf_s3;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			clk_sync <= 3'h0;
			pwr_s1 <= 2'h2;
			pwr_s2 <= 2'h2;
			pwr_s3 <= 2'h2;
			cf_s1 <= 2'h0;
			cf_s2 <= 2'h0;
			cf_s3 <= 2'h0;
		end else begin
			clk_sync <= {clk_sync[1:0], sample_clk};
			pwr_s1 <= power_state_select;
			pwr_s2 <= pwr_s1;
			pwr_s3 <= pwr_s2;
			cf_s1 <= clock_format_select;
			cf_s2 <= cf_s1;
			cf_s3 <= cf_s2;
		end
	end

	// Falling sample-clock edge holds the sample; level trusted once stages agree.
	logic sclk_hi;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) sclk_hi <= 1'b0;
		else if (clk_sync[2] == clk_sync[1]) sclk_hi <= clk_sync[2];
	end
	wire logic hold_edge = sclk_hi && (clk_sync[2] == clk_sync[1]) && !clk_sync[2];

	// Decode of strap levels, accepted once the last two stages agree.
	adcm_pkg::adcm_pwr_t  pwr;
	adcm_pkg::adcm_cfmt_t cfmt;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pwr <= adcm_pkg::ADCM_PWR_DOWN;
			cfmt <= adcm_pkg::ADCM_SE_OFFB;
		end else begin
			if (pwr_s2 == pwr_s3) begin
				case (pwr_s3)
					2'h0:    pwr <= adcm_pkg::ADCM_PWR_ON;
					2'h1:    pwr <= adcm_pkg::ADCM_PWR_SLEEP;
					default: pwr <= adcm_pkg::ADCM_PWR_DOWN;
				endcase
			end
			if (cf_s2 == cf_s3) cfmt <= adcm_pkg::adcm_cfmt_t'(cf_s3);
		end
	end
	wire logic powered = (pwr == adcm_pkg::ADCM_PWR_ON);
	wire logic twos    = (cfmt == adcm_pkg::ADCM_DIFF_TWOS) || (cfmt == adcm_pkg::ADCM_SE_TWOS);
	assign clock_single_ended = !cfmt[1];

	// Settle counter after leaving a low-power state.
	logic [31:0] settle_cnt;
	adcm_pkg::adcm_pwr_t pwr_prev;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			settle_cnt <= 32'h0;
			pwr_prev <= adcm_pkg::ADCM_PWR_DOWN;
		end else begin
			pwr_prev <= pwr;
			if (powered && pwr_prev == adcm_pkg::ADCM_PWR_DOWN)
				settle_cnt <= 32'(EXIT_PD);
			else if (powered && pwr_prev == adcm_pkg::ADCM_PWR_SLEEP)
				settle_cnt <= 32'(EXIT_SL);
			else if (settle_cnt != 32'h0)
				settle_cnt <= settle_cnt - 32'h1;
		end
	end
	// Settling is reported for the whole count so the receiver can discard early words.
	assign settling = (settle_cnt != 32'h0);

	// Format conversion: two's complement flips the top bit of offset binary.
	function automatic logic [13:0] fmt(input logic [13:0] w, input logic t);
		fmt = t ? (w ^ adcm_pkg::SIGN_BIT) : w;
	endfunction

	// Latency pipeline, cleared while not powered so stale samples are dropped.
	adcm_pkg::adcm_sample_t pipe [LATENCY];
	logic [LATENCY-1:0] pvld;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pvld <= '0;
		end else if (!powered) begin
			pvld <= '0;
		end else if (hold_edge) begin
			pvld <= {pvld[LATENCY-2:0], 1'b1};
		end
	end
	always_ff @(posedge clk_sys) begin
		if (hold_edge) begin
			pipe[0] <= '{over: core_over, bits: fmt(core_word, twos)};
			for (int i = 1; i < LATENCY; i++) pipe[i] <= pipe[i-1];
		end
	end

	// Two-entry buffer between pipeline output and the serialiser.
	adcm_pkg::adcm_sample_t buf_mem [2];
	logic [1:0] buf_cnt;
	logic       wr_ptr, rd_ptr;
	wire logic  in_valid  = hold_edge && pvld[LATENCY-1] && powered;
	wire logic  in_ready  = (buf_cnt != 2'h2);
	logic       out_ready;
	wire logic  out_valid = (buf_cnt != 2'h0);
	wire logic  push = in_valid && in_ready;
	// A pop is held off once power is lost, so no strobe starts while the buffer flushes.
	wire logic  pop  = out_valid && out_ready && powered;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			buf_cnt <= 2'h0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
		end else if (!powered) begin
			buf_cnt <= 2'h0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
		end else begin
			if (push) wr_ptr <= !wr_ptr;
			if (pop) rd_ptr <= !rd_ptr;
			buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
		end
	end
	always_ff @(posedge clk_sys) begin
		if (push) buf_mem[wr_ptr] <= pipe[LATENCY-1];
	end

	// Serialiser: odd bits then falling strobe, even bits then rising strobe.
	typedef enum logic [1:0] {ADCM_S_IDLE, ADCM_S_ODD, ADCM_S_EVEN} adcm_ser_t;
	adcm_ser_t ser;
	adcm_pkg::adcm_sample_t cur;
	// The serialiser accepts a new word only from idle or after its even half.
	assign out_ready = (ser == ADCM_S_IDLE) || (ser == ADCM_S_EVEN);
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ser <= ADCM_S_IDLE;
			cur <= '0;
			sample_bits <= 7'h00;
			output_strobe <= 1'b1;
			over_range_flag <= 1'b0;
			data_valid <= 1'b0;
		end else begin
			data_valid <= powered;
			case (ser)
				ADCM_S_IDLE, ADCM_S_EVEN: begin
					if (pop) begin
						cur <= buf_mem[rd_ptr];
						for (int k = 0; k < 7; k++) sample_bits[k] <= buf_mem[rd_ptr].bits[2*k+1];
						over_range_flag <= buf_mem[rd_ptr].over;
						output_strobe <= 1'b0;
						ser <= ADCM_S_ODD;
					end else begin
						ser <= ADCM_S_IDLE;
					end
				end
				ADCM_S_ODD: begin
					for (int k = 0; k < 7; k++) sample_bits[k] <= cur.bits[2*k];
					output_strobe <= 1'b1;
					ser <= ADCM_S_EVEN;
				end
				default: ser <= ADCM_S_IDLE;
			endcase
		end
	end

endmodule : adcm_top

// ---- logic/adcm_pkg.sv ----
// Package for the converter control and double-data-rate output block.
// Assumes a single system clock; all other users refer to names by package scope.
package adcm_pkg;

	localparam int SAMPLE_W    = 14;                 // Width of one converted sample.
	localparam int SYS_CLK_MHZ = 200;                // System clock rate.
	localparam int EXIT_PD_US  = 3000;               // Power-down exit settle time in microseconds.
	localparam int EXIT_PD_CYC = EXIT_PD_US * SYS_CLK_MHZ; // Cycles of settle after power-down.
	localparam int EXIT_SL_US  = 300;                // Sleep exit settle time in microseconds.
	localparam int EXIT_SL_CYC = EXIT_SL_US * SYS_CLK_MHZ;

	// Offset binary mid-scale and two's complement conversion mask.
	localparam logic [13:0] MID_SCALE = 14'h2000;
	localparam logic [13:0] SIGN_BIT  = 14'h2000;

	// Decoded three-level power-state pin.
	typedef enum logic [1:0] {
		ADCM_PWR_ON    = 2'h0,
		ADCM_PWR_SLEEP = 2'h1,
		ADCM_PWR_DOWN  = 2'h2
	} adcm_pwr_t;

	// Decoded four-level clock-and-format pin.
	typedef enum logic [1:0] {
		ADCM_DIFF_TWOS = 2'h3,
		ADCM_DIFF_OFFB = 2'h2,
		ADCM_SE_TWOS   = 2'h1,
		ADCM_SE_OFFB   = 2'h0
	} adcm_cfmt_t;

	// One converted sample with its over-range flag.
	typedef struct packed {
		logic                over;
		logic [SAMPLE_W-1:0] bits;
	} adcm_sample_t;

endpackage : adcm_pkg

// ---- verification/adcm_rx_model.sv ----
// Receiver model that rebuilds each word from the two strobe halves.
// Assumes it samples the outputs on the system clock that launches them.
`timescale 1ns/1ps
module adcm_rx_model (
	input  wire logic             clk_sys,
	input  wire logic [6:0]       sample_bits,
	input  wire logic             output_strobe,
	input  wire logic             over_range_flag,
	output adcm_pkg::adcm_sample_t rx_word,
	output int                    rx_count
);
	logic       strobe_q = 1'b1;
	logic [6:0] odd_q    = 7'h00;
	initial rx_word = '0;
	initial rx_count = 0;
	// Odd bits are taken while the strobe is low, even bits when it rises.
	always @(posedge clk_sys) begin
		strobe_q <= output_strobe;
		if (!output_strobe)
			odd_q <= sample_bits;
		if (output_strobe && !strobe_q) begin
			for (int k = 0; k < 7; k++) begin
				rx_word.bits[2*k+1] <= odd_q[k];
				rx_word.bits[2*k]   <= sample_bits[k];
			end
			rx_word.over <= over_range_flag;
			rx_count     <= rx_count + 1;
		end
	end
endmodule : adcm_rx_model

// ---- verification/adcm_asserts.sv ----
// Checker for the converter output block.
// Assumes it is bound to adcm_top and sees only its ports.
`timescale 1ns/1ps
module adcm_asserts (
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	input wire logic [1:0] power_state_select,
	input wire logic [1:0] clock_format_select,
	input wire logic       output_strobe,
	input wire logic       over_range_flag,
	input wire logic       data_valid,
	input wire logic       clock_single_ended
);
	// All checks run on the system clock and pause during reset.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_no_strobe; (power_state_select != 2'h0) [*6] |-> output_strobe; endproperty
	property p_valid_off; (power_state_select != 2'h0) [*6] |-> !data_valid; endproperty
	property p_valid_on; (power_state_select == 2'h0) [*8] |-> data_valid; endproperty
	property p_strobe_low; $fell(output_strobe) |=> output_strobe; endproperty
	property p_fell_valid; $fell(output_strobe) |-> data_valid || $past(data_valid); endproperty
	property p_se; $stable(clock_format_select) [*8] |-> clock_single_ended == !clock_format_select[1];
	endproperty
	property p_over_hold; $rose(output_strobe) |-> $stable(over_range_flag); endproperty
	property p_strobe_rate; $fell(output_strobe) |=> (!$fell(output_strobe)) [*3]; endproperty
	a_no_strobe: assert property (p_no_strobe) else $error("strobe moved while off");
	a_valid_off: assert property (p_valid_off) else $error("valid while off");
	a_valid_on: assert property (p_valid_on) else $error("not valid while on");
	a_strobe_low: assert property (p_strobe_low) else $error("strobe low too long");
	a_fell_valid: assert property (p_fell_valid) else $error("word sent while off");
	a_se: assert property (p_se) else $error("clock mode wrong");
	a_over_hold: assert property (p_over_hold) else $error("over flag moved in period");
	a_strobe_rate: assert property (p_strobe_rate) else $error("strobe too fast");
	c_word: cover property ($fell(output_strobe));
	c_over: cover property ($rose(over_range_flag));
	c_off: cover property ($fell(data_valid));
endmodule : adcm_asserts

bind adcm_top adcm_asserts u_asserts (.clk_sys, .sys_rst, .power_state_select,
	.clock_format_select, .output_strobe, .over_range_flag, .data_valid, .clock_single_ended);

// ---- verification/testbench.sv ----
// Self-checking bench for the converter output block.
// Assumes adcm_top, the receiver model and the bound checker.
`timescale 1ns/1ps
module testbench;
	typedef struct {logic [1:0] fmt; logic [14:0] din; logic [14:0] dout; logic se;} adcm_row_t;
	logic        clk_sys = 1'b0, sys_rst = 1'b1, sample_clk = 1'b0, core_over = 1'b0;
	logic [1:0]  power_state_select = 2'h0, clock_format_select = 2'h3;
	logic [13:0] core_word = 14'h0000;
	logic [6:0]  sample_bits;
	logic        output_strobe, over_range_flag, data_valid, settling, clock_single_ended;
	adcm_pkg::adcm_sample_t rx_word;
	int          rx_count, n_errors = 0, cmp_count = 0, cyc = 0, n;
	adcm_row_t   rows [4] = '{'{2'h3, 15'h2000, 15'h0000, 1'b0}, '{2'h2, 15'h7FFF, 15'h7FFF, 1'b0},
		'{2'h1, 15'h0000, 15'h2000, 1'b1}, '{2'h0, 15'h5555, 15'h5555, 1'b1}};

	adcm_top #(.LATENCY(8), .EXIT_PD(20), .EXIT_SL(10)) uut (.clk_sys, .sys_rst, .sample_clk,
		.power_state_select, .clock_format_select, .core_word, .core_over, .sample_bits,
		.output_strobe, .over_range_flag, .data_valid, .settling, .clock_single_ended);
	adcm_rx_model rx (.clk_sys, .sample_bits, .output_strobe, .over_range_flag, .rx_word, .rx_count);

	// System clock at 200 MHz.
	initial forever #2.5 clk_sys = ~clk_sys;

	// Free-running 125 ns sample clock and a cap on the run length.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		sample_clk <= (cyc % 25) < 12;
		if (cyc == 20000) begin
			n_errors++;
			final_report();
		end
	end

	// Counts a comparison and reports a mismatch.
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("%0d compares, %0d mismatches", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// Table rows, then low-power codes and a reset in mid-run.
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			clock_format_select <= rows[i].fmt;
			{core_over, core_word} <= rows[i].din;
			repeat (300) @(posedge clk_sys);
			check({1'b0, rx_word}, {1'b0, rows[i].dout});
			check({15'h0, clock_single_ended}, {15'h0, rows[i].se});
			$display("row %0d done", i);
		end
		for (int p = 1; p < 4; p++) begin
			power_state_select <= 2'(p);
			{core_over, core_word} <= 15'(p);
			repeat (50) @(posedge clk_sys);
			check({15'h0, data_valid}, 16'h0000);
			n = rx_count;
			repeat (200) @(posedge clk_sys);
			check(16'(rx_count - n), 16'h0000);
			power_state_select <= 2'h0;
			repeat (20) @(posedge clk_sys);
			check({15'h0, settling}, {15'h0, p != 1});
			repeat (300) @(posedge clk_sys);
			check({15'h0, settling}, 16'h0000);
			check({1'b0, rx_word}, 16'(p));
			$display("power code %0d done", p);
		end
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check({5'h0, output_strobe, over_range_flag, data_valid, settling, sample_bits}, 16'h0400);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check({15'h0, output_strobe}, 16'h0001);
		$display("reset test done");
		final_report();
	end
endmodule : testbench
